// >>> cuc_top.sv
// configurable up/down counter with an AHB-Lite register slave
// assumes one AHB-Lite master, single word transfers, all on mclk;
// counter control pins are synchronous to mclk
//
// Behaviour
// - free-running up: start value first, then add step modulo 2^N
// - free-running down: subtract step each sample, modulo 2^N
// - up/down mode: up input 1 adds, 0 subtracts; logic drives it
// - count-limited: after output equals end value, return to start
// - count-limited down subtracts the step, same return at end
// - count-limited width is at most 64 bits
// - end value configurable, infinite means max; must differ from start
// - with load option, load asserted while enabled puts load data in next output
// - load and load data exist only for the free-running type
// - synchronous reset returns to start, above enable and load
// - output is fixed point: signedness, width, binary point set
`timescale 1ns/10ps
`default_nettype none
`include "cuc_consts.svh"
module cuc_top #(
   parameter int                W         = 16,
   parameter int                BIN_POINT = 0,
   parameter bit                SIGNED    = 1'b0,
   parameter bit                LIMITED   = 1'b0,
   parameter cuc_pkg::cuc_dir_t DIR       = cuc_pkg::CUC_DIR_UP,
   parameter bit                HAS_LOAD  = 1'b1,
   parameter bit                HAS_RST   = 1'b1,
   parameter bit                HAS_EN    = 1'b1,
   parameter logic [63:0]       START     = 64'h0,
   parameter logic [63:0]       END       = 64'h0,
   parameter bit                END_INF   = 1'b1,
   parameter logic [63:0]       STEP      = 64'h1
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rstn,
   // ahb-lite slave
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic [31:0]        hrdata,
   output logic               hresp,
   // counter control from surrounding logic
   input  wire logic          cnt_en,
   input  wire logic          cnt_up,
   input  wire logic          cnt_srst,
   input  wire logic          cnt_load,
   input  wire logic [W-1:0]  cnt_load_data,
   // counter output
   output logic [W-1:0]       cnt_value,
   output logic               cnt_at_end
);
   import cuc_pkg::*;

   if (BIN_POINT < 0 || BIN_POINT > W) begin : g_bad_bp
      $error("binary point outside the word");
   end
   if (W > `CUC_MAX_W) begin : g_bad_w
      $error("counter wider than the register map allows");
   end

   // register front end state
   typedef struct packed {
      cuc_bus_st_t         st;
      logic                ready;
      logic                resp;
      logic [`CUC_AW-1:0]  addr;
      logic                write;
      logic                wr_ok;
      logic [31:0]         rdata;
      logic                run;
      logic                sw_rst;
      logic                sw_load;
      logic [31:0]         ld_lo;
      logic [31:0]         ld_hi;
      logic                wrap_seen;
      logic [31:0]         snap_hi;
   } cuc_top_st_t;

   localparam logic [31:0] CTRL_RST = `CUC_CTRL_RST;

   localparam cuc_top_st_t RST_ST = '{
      st:        CUC_ST_IDLE,
      ready:     1'b1,
      resp:      1'b0,
      addr:      '0,
      write:     1'b0,
      wr_ok:     1'b0,
      rdata:     `CUC_ZERO32,
      run:       CTRL_RST[`CUC_CTRL_RUN],
      sw_rst:    1'b0,
      sw_load:   1'b0,
      ld_lo:     `CUC_ZERO32,
      ld_hi:     `CUC_ZERO32,
      wrap_seen: 1'b0,
      snap_hi:   `CUC_ZERO32};

   cuc_top_st_t q;
   cuc_top_st_t d;

   cuc_ctl_if #(.W(W)) ctl ();

   logic        take;
   logic [63:0] ld64;
   logic [63:0] val64;
   logic [31:0] cfg_word;
   logic [31:0] stat_word;
   logic        en_eff;

   // address phase accepted
   assign take = hsel && hready && htrans[1];

   assign ld64  = {q.ld_hi, q.ld_lo};
   assign val64 = 64'(ctl.value);

   // effective control into the core
   assign en_eff        = (HAS_EN ? cnt_en : 1'b1) && q.run;
   assign ctl.en        = en_eff;
   assign ctl.srst      = cnt_srst || q.sw_rst;
   assign ctl.up        = cnt_up;
   assign ctl.load      = cnt_load || q.sw_load;
   assign ctl.load_data = cnt_load ? cnt_load_data : ld64[W-1:0];

   // read-only configuration word, describes the output format
   always_comb begin
      cfg_word = `CUC_ZERO32;
      cfg_word[`CUC_CFG_W +: 8]  = 8'(W);
      cfg_word[`CUC_CFG_BP +: 8] = 8'(BIN_POINT);
      cfg_word[`CUC_CFG_SGN]     = SIGNED;
      cfg_word[`CUC_CFG_LIM]     = LIMITED;
      cfg_word[`CUC_CFG_DIR +: 2] = DIR;
      cfg_word[`CUC_CFG_LOAD]    = HAS_LOAD && !LIMITED;
   end

   // live status word
   always_comb begin
      stat_word = `CUC_ZERO32;
      stat_word[`CUC_STAT_END]  = ctl.at_end;
      stat_word[`CUC_STAT_WRAP] = q.wrap_seen;
      stat_word[`CUC_STAT_EN]   = en_eff;
   end

   always_comb begin
      d         = q;
      d.sw_rst  = 1'b0;
      d.sw_load = 1'b0;
      // limit return is sticky until software clears it; set wins
      d.wrap_seen = q.wrap_seen || ctl.wrap;
      unique case (q.st)
         CUC_ST_IDLE: begin
            d.ready = 1'b1;
            if (take) begin
               d.st    = CUC_ST_ACC;
               d.ready = 1'b0;
               d.addr  = haddr[`CUC_AW-1:0];
               d.write = hwrite;
               d.wr_ok = (hsize == `CUC_HSIZE_WORD)
                         && (haddr[31:`CUC_AW] == '0);
            end
         end
         CUC_ST_ACC: begin
            d.st    = CUC_ST_IDLE;
            d.ready = 1'b1;
            d.rdata = `CUC_ZERO32;
            if (q.write) begin
               if (q.wr_ok) begin
                  unique case (q.addr)
                     `CUC_OFS_CTRL: begin
                        d.run     = hwdata[`CUC_CTRL_RUN];
                        d.sw_rst  = hwdata[`CUC_CTRL_SRST];
                        d.sw_load = hwdata[`CUC_CTRL_LOAD];
                     end
                     `CUC_OFS_LD_LO: begin
                        d.ld_lo = hwdata;
                     end
                     `CUC_OFS_LD_HI: begin
                        d.ld_hi = hwdata;
                     end
                     `CUC_OFS_STAT: begin
                        d.wrap_seen = (q.wrap_seen
                                       && !hwdata[`CUC_STAT_WRAP])
                                      || ctl.wrap;
                     end
                     default: begin
                     end
                  endcase
               end
            end else begin
               unique case (q.addr)
                  `CUC_OFS_CTRL: begin
                     d.rdata[`CUC_CTRL_RUN] = q.run;
                  end
                  `CUC_OFS_LD_LO: begin
                     d.rdata = q.ld_lo;
                  end
                  `CUC_OFS_LD_HI: begin
                     d.rdata = q.ld_hi;
                  end
                  `CUC_OFS_CNT_LO: begin
                     // high half frozen for a coherent wide read
                     d.rdata   = val64[31:0];
                     d.snap_hi = val64[63:32];
                  end
                  `CUC_OFS_CNT_HI: begin
                     d.rdata = q.snap_hi;
                  end
                  `CUC_OFS_STAT: begin
                     d.rdata = stat_word;
                  end
                  `CUC_OFS_CFG: begin
                     d.rdata = cfg_word;
                  end
                  default: begin
                     d.rdata = `CUC_ZERO32;
                  end
               endcase
            end
         end
         default: begin
            d = RST_ST;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= RST_ST;
      end else begin
         q <= d;
      end
   end

   cuc_core #(
      .W        (W),
      .SIGNED   (SIGNED),
      .LIMITED  (LIMITED),
      .DIR      (DIR),
      .HAS_LOAD (HAS_LOAD),
      .HAS_RST  (HAS_RST),
      .HAS_EN   (HAS_EN),
      .START    (START),
      .END      (END),
      .END_INF  (END_INF),
      .STEP     (STEP)
   ) u_core (
      .mclk (mclk),
      .rstn (rstn),
      .ctl  (ctl.core)
   );

   // outputs, all from flip-flops
   assign hreadyout  = q.ready;
   assign hrdata     = q.rdata;
   assign hresp      = q.resp;
   assign cnt_value  = ctl.value;
   assign cnt_at_end = ctl.at_end;
endmodule : cuc_top
`default_nettype wire

// >>> cuc_consts.svh
// constants of the configurable up/down counter: offsets, fields, resets
// assumes inclusion by bare name from each design file that needs it
`ifndef CUC_CONSTS_SVH
`define CUC_CONSTS_SVH

`define CUC_AW          8
`define CUC_OFS_CTRL    8'h00
`define CUC_OFS_LD_LO   8'h04
`define CUC_OFS_LD_HI   8'h08
`define CUC_OFS_CNT_LO  8'h0c
`define CUC_OFS_CNT_HI  8'h10
`define CUC_OFS_STAT    8'h14
`define CUC_OFS_CFG     8'h18

`define CUC_CTRL_RUN    0
`define CUC_CTRL_SRST   1
`define CUC_CTRL_LOAD   2
`define CUC_CTRL_RST    32'h0000_0001

`define CUC_STAT_END    0
`define CUC_STAT_WRAP   1
`define CUC_STAT_EN     2

`define CUC_CFG_W       0
`define CUC_CFG_BP      8
`define CUC_CFG_SGN     16
`define CUC_CFG_LIM     17
`define CUC_CFG_DIR     18
`define CUC_CFG_LOAD    20

`define CUC_MAX_W       64
`define CUC_HSIZE_WORD  3'b010
`define CUC_ZERO32      32'h0000_0000

`endif

// >>> cuc_pkg.sv
// types of the configurable up/down counter
// assumes cuc_consts.svh carries the numeric constants
package cuc_pkg;
   typedef enum logic [1:0] {
      CUC_DIR_UP     = 2'b00,
      CUC_DIR_DOWN   = 2'b01,
      CUC_DIR_UPDOWN = 2'b10
   } cuc_dir_t;

   typedef enum logic [1:0] {
      CUC_ST_IDLE = 2'b01,
      CUC_ST_ACC  = 2'b10
   } cuc_bus_st_t;
endpackage : cuc_pkg

// >>> cuc_ctl_if.sv
// control and status between register front end and counter core
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface cuc_ctl_if #(parameter int W = 16);
   logic         en;
   logic         srst;
   logic         up;
   logic         load;
   logic [W-1:0] load_data;
   logic [W-1:0] value;
   logic         at_end;
   logic         wrap;

   modport ctrl (output en, srst, up, load, load_data,
                 input  value, at_end, wrap);
   modport core (input  en, srst, up, load, load_data,
                 output value, at_end, wrap);
endinterface : cuc_ctl_if
`default_nettype wire

// >>> cuc_addsub.sv
// add or subtract the step, wrapping modulo 2^W
// assumes purely combinational use
`timescale 1ns/10ps
`default_nettype none
module cuc_addsub #(
   parameter int W = 16
) (
   // operands
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         up,
   // result
   output logic      [W-1:0] y
);
   always_comb begin
      if (up) begin
         y = a + b;
      end else begin
         y = a - b;
      end
   end
endmodule : cuc_addsub
`default_nettype wire

// >>> cuc_core.sv
// counter core: count register, limit compare, load, reset and enable
// assumes control inputs synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
`include "cuc_consts.svh"
module cuc_core #(
   parameter int                W        = 16,
   parameter bit                SIGNED   = 1'b0,
   parameter bit                LIMITED  = 1'b0,
   parameter cuc_pkg::cuc_dir_t DIR      = cuc_pkg::CUC_DIR_UP,
   parameter bit                HAS_LOAD = 1'b1,
   parameter bit                HAS_RST  = 1'b1,
   parameter bit                HAS_EN   = 1'b1,
   parameter logic [63:0]       START    = 64'h0,
   parameter logic [63:0]       END      = 64'h0,
   parameter bit                END_INF  = 1'b1,
   parameter logic [63:0]       STEP     = 64'h1
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // control and status
   cuc_ctl_if.core   ctl
);
   import cuc_pkg::*;

   localparam logic [W-1:0] START_W = START[W-1:0];
   localparam logic [W-1:0] STEP_W  = STEP[W-1:0];
   localparam logic [W-1:0] MAX_W   =
      SIGNED ? {1'b0, {(W-1){1'b1}}} : {W{1'b1}};
   localparam logic [W-1:0] END_W   = END_INF ? MAX_W : END[W-1:0];
   localparam logic [W-1:0] SPAN_UP = END_W - START_W;
   localparam logic [W-1:0] SPAN_DN = START_W - END_W;

   if (W < 2 || W > `CUC_MAX_W) begin : g_bad_w
      $error("counter width out of range");
   end
   if (LIMITED && END_W == START_W) begin : g_bad_end
      $error("ending value equals start value");
   end
   if (LIMITED && STEP_W == '0) begin : g_bad_step
      $error("zero step on a count-limited counter");
   end
   if (LIMITED && STEP_W != '0 && DIR == CUC_DIR_UP
       && (SPAN_UP % STEP_W) != '0) begin : g_bad_up
      $error("step does not divide the up span");
   end
   if (LIMITED && STEP_W != '0 && DIR == CUC_DIR_DOWN
       && (SPAN_DN % STEP_W) != '0) begin : g_bad_dn
      $error("step does not divide the down span");
   end

   typedef struct packed {
      logic [W-1:0] count;
      logic         at_end;
      logic         wrap;
   } cuc_core_st_t;

   localparam cuc_core_st_t RST_ST = '{
      count:  START_W,
      at_end: LIMITED && (START_W == END_W),
      wrap:   1'b0};

   cuc_core_st_t q;
   cuc_core_st_t d;
   logic         dir_up;
   logic [W-1:0] stepped;
   logic         en_eff;

   // direction: fixed by mode or taken from the up input
   assign dir_up = (DIR == CUC_DIR_UP)   ? 1'b1 :
                   (DIR == CUC_DIR_DOWN) ? 1'b0 : ctl.up;
   assign en_eff = HAS_EN ? ctl.en : 1'b1;

   cuc_addsub #(.W(W)) u_step (
      .a  (q.count),
      .b  (STEP_W),
      .up (dir_up),
      .y  (stepped)
   );

   always_comb begin
      d      = q;
      d.wrap = 1'b0;
      if (HAS_RST && ctl.srst) begin
         d.count = START_W;
      end else if (en_eff) begin
         if (HAS_LOAD && !LIMITED && ctl.load) begin
            d.count = ctl.load_data;
         end else if (LIMITED && q.count == END_W) begin
            d.count = START_W;
            d.wrap  = 1'b1;
         end else begin
            d.count = stepped;
         end
      end
      d.at_end = LIMITED && (d.count == END_W);
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= RST_ST;
      end else begin
         q <= d;
      end
   end

   assign ctl.value  = q.count;
   assign ctl.at_end = q.at_end;
   assign ctl.wrap   = q.wrap;
endmodule : cuc_core
`default_nettype wire

// >>> cuc_top_properties.sv
// concurrent checks on the bus and counter ports of cuc_top
// assumes one clock mclk and an async active-low rstn
`timescale 1ns/10ps
`default_nettype none
module cuc_top_properties #(
   parameter int          W     = 16,
   parameter logic [63:0] START = 64'h0,
   parameter logic [63:0] STEP  = 64'h1,
   parameter bit          LIMITED = 1'b0
) (
   // clock and reset
   input wire logic         mclk,
   input wire logic         rstn,
   // bus
   input wire logic         hsel,
   input wire logic [31:0]  haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic         hready,
   input wire logic         hreadyout,
   input wire logic [31:0]  hrdata,
   input wire logic         hresp,
   // counter
   input wire logic         cnt_en,
   input wire logic         cnt_up,
   input wire logic         cnt_srst,
   input wire logic         cnt_load,
   input wire logic [W-1:0] cnt_load_data,
   input wire logic [W-1:0] cnt_value,
   input wire logic         cnt_at_end
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic take;
   assign take = hsel && hready && htrans[1];
   // a ctrl write pulses soft reset or load into the core two edges on
   logic [1:0] ctl_wr;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctl_wr <= 2'b00;
      end else begin
         ctl_wr <= {ctl_wr[0], take && hwrite && haddr[7:0] == 8'h00};
      end
   end

   a_srst_start: assert property (
      cnt_srst |=> cnt_value == START[W-1:0])
      else $error("sync reset did not restore start value");
   a_disabled_hold: assert property (
      !cnt_en && !cnt_srst && !ctl_wr[1] |=> $stable(cnt_value))
      else $error("count moved while disabled");
   a_load_data: assert property (
      cnt_load && cnt_en && !cnt_srst && !ctl_wr[1] |=>
      cnt_value == $past(cnt_load_data) || $stable(cnt_value))
      else $error("load data not taken");
   a_step_up: assert property (
      cnt_en && cnt_up && !cnt_load && !cnt_srst && !ctl_wr[1] |=>
      cnt_value == $past(cnt_value) + STEP[W-1:0] || $stable(cnt_value))
      else $error("up step wrong");
   a_step_down: assert property (
      cnt_en && !cnt_up && !cnt_load && !cnt_srst && !ctl_wr[1] |=>
      cnt_value == $past(cnt_value) - STEP[W-1:0] || $stable(cnt_value))
      else $error("down step wrong");
   a_bus_wait: assert property (take |=> !hreadyout ##1 hreadyout)
      else $error("wait state not one cycle");
   a_resp_okay: assert property (!hresp)
      else $error("response not okay");
   a_unmapped_zero: assert property (
      take && !hwrite && haddr[7:0] == 8'h1c |=> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_end_flag_free: assert property (LIMITED || !cnt_at_end)
      else $error("end flag set on a free-running counter");
endmodule // cuc_top_properties

bind cuc_top cuc_top_properties #(.W(W), .START(START), .STEP(STEP),
   .LIMITED(LIMITED))
   cuc_top_properties_i (.mclk(mclk), .rstn(rstn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .cnt_en(cnt_en), .cnt_up(cnt_up), .cnt_srst(cnt_srst),
   .cnt_load(cnt_load), .cnt_load_data(cnt_load_data),
   .cnt_value(cnt_value), .cnt_at_end(cnt_at_end));
`default_nettype wire

// >>> cuc_partner.sv
// surrounding logic: drives the counter control pins from random bits
// assumes rnd changes once per mclk edge
`timescale 1ns/10ps
`default_nettype none
module cuc_partner #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // stimulus
   input  wire logic        go,
   input  wire logic [31:0] rnd,
   // control pins
   output logic             cnt_en,
   output logic             cnt_up,
   output logic             cnt_srst,
   output logic             cnt_load,
   output logic [W-1:0]     cnt_load_data
);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         {cnt_en, cnt_up, cnt_srst, cnt_load} <= 4'h0;
         cnt_load_data <= '0;
      end else begin
         cnt_en        <= go && rnd[1:0] != 2'h0;
         cnt_up        <= rnd[2];
         cnt_srst      <= go && rnd[7:3] == 5'h00;
         cnt_load      <= go && rnd[11:8] == 4'h0;
         cnt_load_data <= rnd[16 +: W];
      end
   end
endmodule // cuc_partner
`default_nettype wire

// >>> cuc_top_tb.sv
// self-checking bench of cuc_top: bus reads, random pins, count model
// assumes cuc_partner drives the counter pins
`timescale 1ns/10ps
`default_nettype none
module cuc_top_tb;
   localparam int          W     = 16;
   localparam logic [63:0] START = 64'h5;
   localparam logic [63:0] STEP  = 64'h3;
   logic         mclk = 1'b0;
   logic         rstn = 1'b0;
   logic [31:0]  haddr = 32'h0;
   logic [1:0]   htrans = 2'h0;
   logic         hwrite = 1'b0;
   logic [2:0]   hsize = 3'h2;
   logic [31:0]  hwdata = 32'h0;
   logic         hreadyout, hresp, cnt_at_end;
   logic [31:0]  hrdata, rd;
   logic         cnt_en, cnt_up, cnt_srst, cnt_load;
   logic [W-1:0] cnt_load_data, cnt_value;
   logic         go = 1'b0;
   logic         run = 1'b1;
   logic         swr = 1'b0;
   logic         swl = 1'b0;
   logic         ph = 1'b0;
   logic [7:0]   wa = 8'h0;
   logic [31:0]  ld_m = 32'h0;
   logic [31:0]  rnd = 32'h0000_43da;
   int           fail_count = 0;
   int           total_checks = 0;
   int           cycles = 0;
   int           m;

   always #4 mclk = ~mclk;

   cuc_top #(.W(W), .BIN_POINT(4), .SIGNED(1'b1), .START(START),
      .DIR(cuc_pkg::CUC_DIR_UPDOWN), .STEP(STEP)) cuc_top_i (
      .mclk(mclk), .rstn(rstn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .cnt_en(cnt_en), .cnt_up(cnt_up),
      .cnt_srst(cnt_srst), .cnt_load(cnt_load),
      .cnt_load_data(cnt_load_data), .cnt_value(cnt_value),
      .cnt_at_end(cnt_at_end));

   cuc_partner #(.W(W)) cuc_partner_i (.mclk(mclk), .rstn(rstn),
      .go(go), .rnd(rnd), .cnt_en(cnt_en), .cnt_up(cnt_up),
      .cnt_srst(cnt_srst), .cnt_load(cnt_load),
      .cnt_load_data(cnt_load_data));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one single word transfer, entered just after a rising edge
   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // count model, compared at every edge; snoops ctrl and load writes
   always @(posedge mclk) begin
      rnd <= lfsr(rnd);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish;
      end else if (!rstn) begin
         m = int'(START);
         run = 1'b1;
         swr = 1'b0;
         swl = 1'b0;
         ph = 1'b0;
         ld_m = 32'h0;
      end else begin
         check({16'h0, cnt_value}, m);
         check({31'h0, cnt_at_end}, 32'h0);
         if (cnt_srst || swr)
            m = int'(START);
         else if (cnt_en && run) begin
            if (cnt_load)
               m = int'(cnt_load_data);
            else if (swl)
               m = ld_m & 32'h0000_ffff;
            else if (cnt_up)
               m = (m + int'(STEP)) & 32'h0000_ffff;
            else
               m = (m - int'(STEP)) & 32'h0000_ffff;
         end
         swr = 1'b0;
         swl = 1'b0;
         if (ph && wa == 8'h00) begin
            run = hwdata[0];
            swr = hwdata[1];
            swl = hwdata[2];
         end else if (ph && wa == 8'h04)
            ld_m = hwdata;
         ph = htrans == 2'h2 && hreadyout === 1'b1 && hwrite;
         wa = haddr[7:0];
      end
   end

   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      check({31'h0, hreadyout}, 32'h1);
      check(hrdata, 32'h0);
      bus(32'h18, 1'b0, 32'h0);
      check(rd, 32'h0019_0410);
      bus(32'h1c, 1'b1, 32'hffff_ffff);
      bus(32'h1c, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(32'h0, 1'b0, 32'h0);
      check({31'h0, rd[0]}, 32'h1);
      go <= 1'b1;
      repeat (3000) @(posedge mclk);
      for (int i = 0; i < 2; i++) begin
         go <= 1'b0;
         bus(32'h0, 1'b1, {31'h0, i[0]});
         repeat (2) @(posedge mclk);
         go <= 1'b1;
         repeat (800) @(posedge mclk);
      end
      go <= 1'b0;
      repeat (2) @(posedge mclk);
      bus(32'h0c, 1'b0, 32'h0);
      check(rd, m);
      bus(32'h10, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(32'h14, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(32'h04, 1'b1, 32'h0000_a5c3);
      bus(32'h08, 1'b1, 32'h1234_5678);
      bus(32'h08, 1'b0, 32'h0);
      check(rd, 32'h1234_5678);
      go <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         bus(32'h0, 1'b1, 32'h5);
         bus(32'h0, 1'b1, 32'h3);
         repeat (20) @(posedge mclk);
      end
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      check({31'h0, hreadyout}, 32'h1);
      check(hrdata, 32'h0);
      repeat (100) @(posedge mclk);
      tally_and_finish;
   end
endmodule // cuc_top_tb
`default_nettype wire
